// >>> logic/atm_seq.sv
// Purpose: Primary conversion sequencing, alarms, temperature loop.
// Assumes: Converters sit on core_clk_in and answer with done pulses.
// Notes: Registers over APB; all outputs registered.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module atm_seq #(
    parameter int AVAIL_CYC = atm_pkg::AVAIL_PULSE_CYC,
    parameter int HITS = atm_pkg::ALARM_HITS
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic ext_convert_trigger_n_in,
    output logic adc_start_out,
    output logic [3:0] adc_chan_out,
    output logic adc_range_double_out,
    output logic adc_diff_out,
    input wire logic adc_done_in,
    input wire logic [11:0] adc_data_in,
    output logic temp_start_out,
    output logic [1:0] temp_sensor_out,
    input wire logic temp_done_in,
    input wire logic [11:0] temp_data_in,
    output logic data_available_n_out,
    output logic alarm_n_out
);
    // First enabled channel at or above start, 16 when none
    function automatic logic [4:0] next_chan(input logic [15:0] mask,
                                             input logic [4:0] start);
        logic [4:0] r;
        r = 5'h10;
        for (int i = 15; i >= 0; i--) begin
            if (mask[i] && (5'(i) >= start)) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : next_chan

    logic [15:0] chsel_reg;
    logic [17:0] range_reg;
    logic [2:0] tcfg_reg;
    logic auto_reg, avail_flag_reg, pend_reg;
    logic [6:0] status_reg;
    logic [31:0] adc_lim_reg, tmp_lim_reg;
    logic [11:0] tmp_buf_reg [16];
    logic [11:0] data_reg [16];
    logic [11:0] temp_res_reg [3];
    logic [2:0] trig_sync_reg;
    logic [4:0] ch_reg;
    atm_pkg::atm_prim_t pst_reg;
    atm_pkg::atm_temp_t tst_reg;
    logic [1:0] ts_reg;
    logic [1:0] hit_reg [7];
    logic [7:0] avail_cnt_reg;

    logic wr_acc, host_conv, ext_fall, trig, grp_done, restart, t_none;
    logic [4:0] nxt;
    logic [11:0] adc_word;
    logic [6:0] oor, hit_set;
    logic [1:0] t_nxt;

    // Register access phase completes when pready is high
    assign wr_acc = psel_in & penable_in & pready_out & pwrite_in;
    assign host_conv = wr_acc && paddr_in == atm_pkg::OFS_CFG
                       && pwdata_in[atm_pkg::CFG_CONV_BIT];

    // Trigger synchroniser and single-edge detector
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            trig_sync_reg <= 3'h7;
        end else begin
            trig_sync_reg <= {trig_sync_reg[1:0], ext_convert_trigger_n_in};
        end
    end
    assign ext_fall = trig_sync_reg[2] & ~trig_sync_reg[1];
    assign trig = ext_fall | host_conv;

    // Channel word: differential pairs recoded to two's complement
    assign adc_word = adc_diff_out ? {~adc_data_in[11], adc_data_in[10:0]}
                                   : adc_data_in;

    assign nxt = next_chan(chsel_reg, ch_reg + 5'h01);
    assign grp_done = (pst_reg == atm_pkg::P_WAIT) && adc_done_in
                      && nxt == 5'h10;
    assign restart = grp_done && (pend_reg || trig || auto_reg);

    // Primary sequencer
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pst_reg <= atm_pkg::P_IDLE;
            ch_reg <= 5'h00;
            adc_start_out <= 1'b0;
            adc_chan_out <= 4'h0;
            adc_range_double_out <= 1'b0;
            adc_diff_out <= 1'b0;
        end else begin
            adc_start_out <= 1'b0;
            case (pst_reg)
                atm_pkg::P_IDLE: begin
                    if (trig && chsel_reg != 16'h0000) begin
                        ch_reg <= next_chan(chsel_reg, 5'h00);
                        pst_reg <= atm_pkg::P_START;
                    end
                end
                atm_pkg::P_START: begin
                    adc_start_out <= 1'b1;
                    adc_chan_out <= ch_reg[3:0];
                    adc_range_double_out <= range_reg[ch_reg[3:0]];
                    adc_diff_out <= (ch_reg < 5'h02
                                     && range_reg[atm_pkg::RANGE_DIFF01_BIT])
                                    || (ch_reg[4:1] == 4'h1
                                     && range_reg[atm_pkg::RANGE_DIFF23_BIT]);
                    pst_reg <= atm_pkg::P_WAIT; // bipolar when set
                end
                atm_pkg::P_WAIT: begin
                    // A trigger here does not abort the channel
                    if (adc_done_in) begin
                        if (nxt != 5'h10) begin
                            ch_reg <= nxt;
                            pst_reg <= atm_pkg::P_START;
                        end else if (restart && chsel_reg != 16'h0000) begin
                            ch_reg <= next_chan(chsel_reg, 5'h00);
                            pst_reg <= atm_pkg::P_START;
                        end else begin
                            pst_reg <= atm_pkg::P_IDLE;
                        end
                    end
                end
                default: pst_reg <= atm_pkg::P_IDLE;
            endcase
        end
    end

    // Pending trigger seen mid-cycle; cleared at group end, where a same-cycle trigger restarts directly
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pend_reg <= 1'b0;
        end else if (trig && pst_reg != atm_pkg::P_IDLE && !grp_done) begin
            pend_reg <= 1'b1;
        end else if (grp_done) begin
            pend_reg <= 1'b0;
        end
    end

    // Double-buffered results: staged per channel, committed per group
    always_ff @(posedge core_clk_in) begin
        if (pst_reg == atm_pkg::P_WAIT && adc_done_in) begin
            tmp_buf_reg[ch_reg[3:0]] <= adc_word;
        end
        if (grp_done) begin
            for (int i = 0; i < 16; i++) begin
                data_reg[i] <= (5'(i) == ch_reg) ? adc_word : tmp_buf_reg[i];
            end
        end
    end

    // Data-ready indication: auto pulse or direct held level
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            avail_flag_reg <= 1'b0;
            avail_cnt_reg <= 8'h00;
            data_available_n_out <= 1'b1;
        end else begin
            if (grp_done && !auto_reg && !restart) begin
                avail_flag_reg <= 1'b1;
            end else if (wr_acc && paddr_in == atm_pkg::OFS_CFG
                         && pwdata_in[atm_pkg::CFG_FLAG_BIT]) begin
                avail_flag_reg <= 1'b0;
            end
            if (grp_done && auto_reg) begin
                avail_cnt_reg <= 8'(AVAIL_CYC);
            end else if (avail_cnt_reg != 8'h00) begin
                avail_cnt_reg <= avail_cnt_reg - 8'h01;
            end
            data_available_n_out <= ~((grp_done && (auto_reg || !restart))
                                      || avail_flag_reg
                                      || avail_cnt_reg > 8'h01);
        end
    end

    // Temperature loop: next enabled sensor after the current one
    always_comb begin
        t_nxt = 2'h0;
        t_none = 1'b1;
        for (int k = 3; k >= 1; k--) begin
            if (tcfg_reg[(int'(ts_reg) + k) % 3]) begin
                t_nxt = 2'((int'(ts_reg) + k) % 3);
                t_none = 1'b0;
            end
        end
    end

    // Background temperature sequencer, free of the primary one
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tst_reg <= atm_pkg::T_PICK;
            ts_reg <= 2'h2;
            temp_start_out <= 1'b0;
            temp_sensor_out <= 2'h0;
        end else begin
            temp_start_out <= 1'b0;
            case (tst_reg)
                atm_pkg::T_PICK: begin
                    if (!t_none) begin
                        ts_reg <= t_nxt;
                        tst_reg <= atm_pkg::T_START;
                    end
                end
                atm_pkg::T_START: begin
                    temp_start_out <= 1'b1;
                    temp_sensor_out <= ts_reg;
                    tst_reg <= atm_pkg::T_WAIT;
                end
                atm_pkg::T_WAIT: begin
                    if (temp_done_in) begin
                        tst_reg <= atm_pkg::T_PICK;
                    end
                end
                default: tst_reg <= atm_pkg::T_PICK;
            endcase
        end
    end

    // Temperature results, one register per sensor
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < 3; i++) begin
                temp_res_reg[i] <= 12'h000;
            end
        end else if (tst_reg == atm_pkg::T_WAIT && temp_done_in) begin
            temp_res_reg[ts_reg] <= temp_data_in;
        end
    end

    // Out-of-range checks: bits 3..0 channels, 6..4 sensors
    always_comb begin
        oor = 7'h00;
        if (pst_reg == atm_pkg::P_WAIT && adc_done_in && ch_reg < 5'h04) begin
            oor[ch_reg[1:0]] = adc_word > adc_lim_reg[27:16]
                               || adc_word < adc_lim_reg[11:0];
        end
        if (tst_reg == atm_pkg::T_WAIT && temp_done_in) begin
            oor[3'h4 + {1'b0, ts_reg}] =
                $signed(temp_data_in) > $signed(tmp_lim_reg[27:16])
                || $signed(temp_data_in) < $signed(tmp_lim_reg[11:0]);
        end
    end

    // False-alarm filter: consecutive hits counted per source
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < 7; i++) begin
                hit_reg[i] <= 2'h0;
            end
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (oor[i] && hit_reg[i] != 2'(HITS)) begin
                    hit_reg[i] <= hit_reg[i] + 2'h1;
                end else if ((i < 4 && pst_reg == atm_pkg::P_WAIT
                              && adc_done_in && ch_reg == 5'(i))
                             || (i >= 4 && tst_reg == atm_pkg::T_WAIT
                              && temp_done_in && ts_reg == 2'(i - 4))) begin
                    hit_reg[i] <= oor[i] ? hit_reg[i] : 2'h0;
                end
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            hit_set[i] = oor[i] && hit_reg[i] >= 2'(HITS - 1);
        end
    end

    // Status flags: write one to clear, a new hit wins
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_reg <= 7'h00;
            alarm_n_out <= 1'b1;
        end else begin
            if (wr_acc && paddr_in == atm_pkg::OFS_STATUS) begin
                status_reg <= (status_reg & ~pwdata_in[6:0]) | hit_set;
            end else begin
                status_reg <= status_reg | hit_set;
            end
            alarm_n_out <= ~(|status_reg);
        end
    end

    // Host-written configuration registers
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            chsel_reg <= atm_pkg::CHSEL_RST;
            range_reg <= 18'h00000;
            tcfg_reg <= atm_pkg::TCFG_RST;
            auto_reg <= 1'b0;
            adc_lim_reg <= atm_pkg::ADC_LIM_RST;
            tmp_lim_reg <= atm_pkg::TMP_LIM_RST;
        end else if (wr_acc) begin
            case (paddr_in)
                atm_pkg::OFS_CFG: auto_reg <= pwdata_in[atm_pkg::CFG_AUTO_BIT];
                atm_pkg::OFS_CHSEL: chsel_reg <= pwdata_in[15:0];
                atm_pkg::OFS_RANGE: range_reg <= pwdata_in[17:0];
                atm_pkg::OFS_TCFG: tcfg_reg <= pwdata_in[2:0];
                atm_pkg::OFS_ADC_LIM: adc_lim_reg <= pwdata_in;
                atm_pkg::OFS_TMP_LIM: tmp_lim_reg <= pwdata_in;
                default: ;
            endcase
        end
    end

    // APB answer: one wait state, read data and error registered
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else begin
            pready_out <= psel_in & penable_in & ~pready_out;
            pslverr_out <= 1'b0;
            if (psel_in && penable_in && !pready_out) begin
                prdata_out <= 32'h0;
                if (paddr_in[11:6] == 6'h01 && paddr_in[1:0] == 2'h0) begin
                    prdata_out <= {20'h00000, data_reg[paddr_in[5:2]]};
                end else begin
                    case (paddr_in)
                        atm_pkg::OFS_CFG: prdata_out <= {29'h0, avail_flag_reg,
                                                         auto_reg, 1'b0};
                        atm_pkg::OFS_CHSEL: prdata_out <= {16'h0, chsel_reg};
                        atm_pkg::OFS_RANGE: prdata_out <= {14'h0, range_reg};
                        atm_pkg::OFS_TCFG: prdata_out <= {29'h0, tcfg_reg};
                        atm_pkg::OFS_STATUS: prdata_out <= {25'h0, status_reg};
                        atm_pkg::OFS_ADC_LIM: prdata_out <= adc_lim_reg;
                        atm_pkg::OFS_TMP_LIM: prdata_out <= tmp_lim_reg;
                        atm_pkg::OFS_LOCAL_T:
                            prdata_out <= {20'h0, temp_res_reg[0]};
                        atm_pkg::OFS_REM1_T:
                            prdata_out <= {20'h0, temp_res_reg[1]};
                        atm_pkg::OFS_REM2_T:
                            prdata_out <= {20'h0, temp_res_reg[2]};
                        default: pslverr_out <= 1'b1;
                    endcase
                end
                if (pwrite_in) begin
                    prdata_out <= 32'h0;
                end
            end
        end
    end
endmodule : atm_seq
`default_nettype wire

// >>> logic/atm_pkg.sv
// Purpose: Constants for conversion sequencing and temperature loop.
// Assumes: APB register map, 20 MHz core clock.
`default_nettype none
package atm_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_CFG = 12'h000;
    localparam logic [11:0] OFS_CHSEL = 12'h004;
    localparam logic [11:0] OFS_RANGE = 12'h008;
    localparam logic [11:0] OFS_TCFG = 12'h00c;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    localparam logic [11:0] OFS_ADC_LIM = 12'h014;
    localparam logic [11:0] OFS_TMP_LIM = 12'h018;
    localparam logic [11:0] OFS_LOCAL_T = 12'h020;
    localparam logic [11:0] OFS_REM1_T = 12'h024;
    localparam logic [11:0] OFS_REM2_T = 12'h028;
    localparam logic [11:0] OFS_DATA0 = 12'h040;
    // Configuration bit positions
    localparam int CFG_CONV_BIT = 0;
    localparam int CFG_AUTO_BIT = 1;
    localparam int CFG_FLAG_BIT = 2;
    localparam int RANGE_DIFF01_BIT = 16;
    localparam int RANGE_DIFF23_BIT = 17;
    // Reset values
    localparam logic [15:0] CHSEL_RST = 16'h0000;
    localparam logic [2:0] TCFG_RST = 3'h7;
    localparam logic [31:0] ADC_LIM_RST = 32'h0fff_0000;
    localparam logic [31:0] TMP_LIM_RST = 32'h07ff_0800;
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int AVAIL_PULSE_NS = 1000;
    localparam int AVAIL_PULSE_CYC = AVAIL_PULSE_NS / CLK_PERIOD_NS;
    localparam int ALARM_HITS = 3;
    // Sequencer states
    typedef enum logic [1:0] {P_IDLE, P_START, P_WAIT} atm_prim_t;
    typedef enum logic [1:0] {T_PICK, T_START, T_WAIT} atm_temp_t;
endpackage : atm_pkg
`default_nettype wire

// >>> verification/atm_conv_model.sv
// Purpose: Converter pair answering starts with dones.
// Assumes: One-cycle starts; slow_in lengthens the primary.
// Notes: Idle data lines toggle so stale codes never match.
`timescale 1ns/1ps
`default_nettype none
module atm_conv_model (
    input wire logic core_clk_in,
    input wire logic adc_start_in,
    input wire logic temp_start_in,
    input wire logic [1:0] temp_sensor_in,
    input wire logic slow_in,
    input wire logic [11:0] adc_code_in,
    output logic adc_done_out,
    output logic [11:0] adc_data_out,
    output logic temp_done_out,
    output logic [11:0] temp_data_out
);
    logic [3:0] adc_cnt = 4'h0;
    logic [1:0] temp_cnt = 2'h0;
    logic [11:0] temp_code;
    // Codes for +25, +150 and -25 degrees
    assign temp_code = (temp_sensor_in == 2'h0) ? 12'h0c8 :
        ((temp_sensor_in == 2'h1) ? 12'h4b0 : 12'hf38);
    // One done for each start, after a short or long latency
    always @(posedge core_clk_in) begin
        if (adc_start_in) begin
            adc_cnt <= slow_in ? 4'hc : 4'h2;
        end else if (adc_cnt != 4'h0) begin
            adc_cnt <= adc_cnt - 4'h1;
        end
        adc_done_out <= (adc_cnt == 4'h1);
        adc_data_out <= (adc_cnt == 4'h1) ? adc_code_in : ~adc_data_out;
        if (temp_start_in) begin
            temp_cnt <= 2'h3;
        end else if (temp_cnt != 2'h0) begin
            temp_cnt <= temp_cnt - 2'h1;
        end
        temp_done_out <= (temp_cnt == 2'h1);
        temp_data_out <= (temp_cnt == 2'h1) ? temp_code : ~temp_data_out;
    end
endmodule : atm_conv_model
`default_nettype wire

// >>> verification/atm_seq_assertions.sv
// Purpose: Port-level checks on the sequencer.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to every instance of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module atm_seq_assertions #(
    parameter int AVAIL_CYC = 20,
    parameter int HITS = 3
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic adc_start_out,
    input wire logic [3:0] adc_chan_out,
    input wire logic adc_done_in,
    input wire logic temp_start_out,
    input wire logic [1:0] temp_sensor_out,
    input wire logic temp_done_in,
    input wire logic data_available_n_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    logic busy_reg;
    logic [7:0] low_cnt;
    // Channel in flight between its start and its done
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_reg <= 1'b0;
        end else if (adc_start_out) begin
            busy_reg <= 1'b1;
        end else if (adc_done_in) begin
            busy_reg <= 1'b0;
        end
    end
    // Length of the current low stretch of the ready pin
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            low_cnt <= 8'h00;
        end else if (data_available_n_out) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hff) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end
    sequence apb_access;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence apb_answer;
        pready_out ##1 !pready_out;
    endsequence
    apb_wait_a: assert property (apb_access |=> apb_answer)
        else $error("access not answered after one wait");
    slverr_ready_a: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    start_pulse_a: assert property (adc_start_out |=> !adc_start_out)
        else $error("channel start too long");
    no_abort_a: assert property (adc_start_out |-> !busy_reg)
        else $error("channel started while busy");
    chan_hold_a: assert property
        (!adc_start_out |-> $stable(adc_chan_out))
        else $error("channel changed between starts");
    temp_pulse_a: assert property
        (temp_start_out |=> !temp_start_out)
        else $error("sensor start too long");
    temp_restart_a: assert property
        (temp_done_in |-> ##[1:4] temp_start_out)
        else $error("temperature loop stalled");
    sensor_hold_a: assert property
        (!temp_start_out |-> $stable(temp_sensor_out))
        else $error("sensor changed mid conversion");
    sensor_valid_a: assert property
        (temp_start_out |-> temp_sensor_out != 2'h3)
        else $error("start for missing sensor");
    avail_width_a: assert property
        ($rose(data_available_n_out) |-> low_cnt >= AVAIL_CYC)
        else $error("ready pulse too short");
endmodule : atm_seq_assertions
bind atm_seq atm_seq_assertions #(.AVAIL_CYC(AVAIL_CYC), .HITS(HITS)) u_chk (
    .*
);
`default_nettype wire

// >>> verification/atm_seq_tb_top.sv
// Purpose: Self-checking bench for the sequencer.
// Assumes: Model answers each start; short ready pulse.
// Notes: Scenarios judge a log of starts; s_regs and s_alarm judge register reads and pins only.
`timescale 1ns/1ps
`default_nettype none
module atm_seq_tb_top;
    localparam int AVAIL = 4;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic ext_convert_trigger_n_in = 1'b1;
    logic slow = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [11:0] code = 12'h123;
    logic [31:0] pwdata_in = 32'h0000_0000;
    logic [31:0] prdata_out, rdat;
    logic [3:0] adc_chan_out;
    logic [1:0] temp_sensor_out;
    logic [11:0] adc_data_in, temp_data_in;
    logic pready_out, pslverr_out, adc_start_out, adc_range_double_out;
    logic adc_diff_out, adc_done_in, temp_start_out, temp_done_in, err;
    logic data_available_n_out, alarm_n_out;
    logic [5:0] aq[$];
    logic [1:0] tq[$];
    int n_mismatch = 0;
    int n_compared = 0;
    // Core clock, 50 ns period
    initial begin
        forever #25 core_clk_in = ~core_clk_in;
    end
    atm_seq #(.AVAIL_CYC(AVAIL)) DUT (
        .*
    );
    atm_conv_model u_model (
        .core_clk_in, .adc_start_in(adc_start_out),
        .temp_start_in(temp_start_out), .temp_sensor_in(temp_sensor_out),
        .slow_in(slow), .adc_code_in(code), .adc_done_out(adc_done_in),
        .adc_data_out(adc_data_in), .temp_done_out(temp_done_in),
        .temp_data_out(temp_data_in)
    );
    // Start log: {diff, range, channel}; sensors
    always @(posedge core_clk_in) begin
        if (adc_start_out === 1'b1) begin
            aq.push_back({adc_diff_out, adc_range_double_out, adc_chan_out});
        end
        if (temp_start_out === 1'b1) begin
            tq.push_back(temp_sensor_out);
        end
    end
    task automatic end_sim;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        i = 0;
        do begin
            @(posedge core_clk_in);
            i++;
        end while (pready_out !== 1'b1 && i < 20);
        rdat = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (pready_out !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
        @(posedge core_clk_in);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                      input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rdat);
    endtask : rd
    task automatic wait_avail(input logic lvl);
        int i;
        for (i = 0; i < 3000 && data_available_n_out !== lvl; i++) begin
            @(posedge core_clk_in);
        end
        if (data_available_n_out !== lvl) begin
            n_mismatch++;
            end_sim();
        end
    endtask : wait_avail
    task automatic trig(input int len);
        ext_convert_trigger_n_in <= 1'b0;
        repeat (len) @(posedge core_clk_in);
        ext_convert_trigger_n_in <= 1'b1;
        @(posedge core_clk_in);
    endtask : trig
    // One direct-mode group by pin or by command, up to its ready level
    task automatic group(input logic pin);
        aq.delete();
        apb(1'b1, atm_pkg::OFS_CFG, pin ? 32'h4 : 32'h5);
        if (pin) trig(10);
        wait_avail(1'b1);
        wait_avail(1'b0);
    endtask : group
    task automatic s_regs;
        rd(atm_pkg::OFS_TCFG, {29'h0, atm_pkg::TCFG_RST}, "tcfg");
        rd(atm_pkg::OFS_CHSEL, 32'h0, "chsel");
        rd(atm_pkg::OFS_ADC_LIM, atm_pkg::ADC_LIM_RST, "adc lim");
        rd(atm_pkg::OFS_TMP_LIM, atm_pkg::TMP_LIM_RST, "tmp lim");
        rd(12'h030, 32'h0, "unmapped");
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("alarm idle", 32'h1, {31'h0, alarm_n_out});
    endtask : s_regs
    task automatic s_trig;
        apb(1'b1, atm_pkg::OFS_CHSEL, 32'h5);
        apb(1'b1, atm_pkg::OFS_RANGE, 32'h1);
        tq.delete();
        group(1'b1);
        repeat (30) @(posedge core_clk_in);
        chk("start count", 32'd2, 32'(aq.size()));
        chk("first start", 32'h10, 32'(aq[0]));
        chk("second start", 32'h02, 32'(aq[1]));
        chk("temp alongside", 32'h1, 32'(tq.size() > 0));
        rd(atm_pkg::OFS_CFG, 32'h4, "ready flag");
        chk("ready held", 32'h0, {31'h0, data_available_n_out});
        rd(atm_pkg::OFS_DATA0 + 12'h8, {20'h0, code}, "ch2 data");
        apb(1'b1, atm_pkg::OFS_CFG, 32'h4);
        @(posedge core_clk_in);
        chk("ready released", 32'h1, {31'h0, data_available_n_out});
    endtask : s_trig
    task automatic s_mid;
        int i;
        slow <= 1'b1;
        aq.delete();
        trig(2);
        for (i = 0; i < 100 && aq.size() == 0; i++) @(posedge core_clk_in);
        repeat (3) @(posedge core_clk_in);
        trig(2);
        repeat (150) @(posedge core_clk_in);
        chk("restart count", 32'd4, 32'(aq.size()));
        chk("kept going", 32'h02, 32'(aq[1]));
        chk("restart first", 32'h10, 32'(aq[2]));
        chk("restart second", 32'h02, 32'(aq[3]));
        slow <= 1'b0;
    endtask : s_mid
    task automatic s_diff;
        apb(1'b1, atm_pkg::OFS_RANGE, 32'h1_0000);
        code <= 12'h800;
        group(1'b0);
        chk("cmd starts", 32'd2, 32'(aq.size()));
        chk("diff start", 32'h20, 32'(aq[0]));
        rd(atm_pkg::OFS_CFG, 32'h4, "cmd reads 0");
        rd(atm_pkg::OFS_DATA0, 32'h0, "diff data");
        rd(atm_pkg::OFS_DATA0 + 12'h8, 32'h800, "single data");
    endtask : s_diff
    task automatic s_alarm;
        apb(1'b1, atm_pkg::OFS_RANGE, 32'h0);
        apb(1'b1, atm_pkg::OFS_ADC_LIM, 32'h0100_0000);
        code <= 12'h200;
        group(1'b0);
        group(1'b0);
        rd(atm_pkg::OFS_STATUS, 32'h0, "early status");
        chk("no early alarm", 32'h1, {31'h0, alarm_n_out});
        group(1'b0);
        rd(atm_pkg::OFS_STATUS, 32'h5, "alarm status");
        chk("alarm low", 32'h0, {31'h0, alarm_n_out});
        code <= 12'h050;
        group(1'b0);
        apb(1'b1, atm_pkg::OFS_STATUS, 32'h7f);
        rd(atm_pkg::OFS_STATUS, 32'h0, "cleared status");
        chk("alarm high", 32'h1, {31'h0, alarm_n_out});
    endtask : s_alarm
    task automatic s_temp;
        apb(1'b1, atm_pkg::OFS_TCFG, 32'h5);
        repeat (20) @(posedge core_clk_in);
        tq.delete();
        repeat (60) @(posedge core_clk_in);
        chk("temp runs", 32'h1, 32'(tq.size() >= 6));
        foreach (tq[i]) chk("skip", 32'h1, 32'(tq[i] != 2'h1));
        rd(atm_pkg::OFS_LOCAL_T, 32'h0c8, "local");
        rd(atm_pkg::OFS_REM1_T, 32'h4b0, "remote one");
        rd(atm_pkg::OFS_REM2_T, 32'hf38, "remote two");
    endtask : s_temp
    task automatic s_auto;
        int n;
        apb(1'b1, atm_pkg::OFS_CFG, 32'h6);
        trig(2);
        wait_avail(1'b0);
        n = 0;
        while (data_available_n_out === 1'b0 && n < 100) begin
            @(posedge core_clk_in);
            n++;
        end
        chk("ready pulse", 32'(AVAIL), 32'(n));
        aq.delete();
        repeat (40) @(posedge core_clk_in);
        chk("auto repeats", 32'h1, 32'(aq.size() > 0));
    endtask : s_auto
    // Reset, then every scenario in turn
    initial begin
        repeat (20) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        @(posedge core_clk_in);
        s_regs();
        s_trig();
        s_mid();
        s_diff();
        s_alarm();
        s_temp();
        s_auto();
        end_sim();
    end
endmodule : atm_seq_tb_top
`default_nettype wire
